/* verilog/tei_pkg.sv */
// Purpose: constants and types shared by the timing edge interrupt controller
// Assumes: register offsets are byte addresses on a 32-bit register bus
// Notes: every field sits in the low byte of its register
package tei_pkg;

    // register bus geometry, source field width and number of timing signals
    localparam int DATA_W = 32;
    localparam int ADDR_W = 6;
    localparam int SRC_W = 7;
    localparam int NUM_SIGNALS = 3;

    // register offsets
    localparam logic [5:0] ENABLE_OFFSET = 6'h20;
    localparam logic [5:0] LIVE_STATUS_OFFSET = 6'h24;
    localparam logic [5:0] FLAG_OFFSET = 6'h28;

    // field positions, shared by enable, live status and flag registers
    localparam int GATE_RISING_BIT = 0;
    localparam int SYNC_RISING_BIT = 1;
    localparam int PULSE_SECOND_RISING_BIT = 2;
    localparam int FALLING_BASE_BIT = 4;
    localparam int GATE_FALLING_BIT = 4;
    localparam int SYNC_FALLING_BIT = 5;
    localparam int PULSE_SECOND_FALLING_BIT = 6;

    // implemented bits; bit 3 and bits 31:7 are reserved
    localparam logic [6:0] FIELD_MASK = 7'h77;

    // reset values
    localparam logic [6:0] ENABLE_RESET = 7'h00;
    localparam logic [6:0] LIVE_STATUS_RESET = 7'h00;
    localparam logic [6:0] FLAG_RESET = 7'h00;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_ENABLE = 2'b01,
        SEL_STATUS = 2'b10,
        SEL_FLAG = 2'b11
    } tei_reg_sel_t;

endpackage

/* verilog/tei_edge_source.sv */
// Purpose: one-cycle rising and falling edge conditions of one selected signal
// Assumes: level_in is produced by logic on clk_in, so it is not synchronised
// Notes: outputs are registered and lag the input change by one cycle
`timescale 1ns/1ns
module tei_edge_source (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic level_in,
    output logic rise_out,
    output logic fall_out
);

    typedef struct packed {
        logic prev;
        logic rise;
        logic fall;
    } tei_edge_state_t;

    tei_edge_state_t st;
    tei_edge_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.prev = level_in;
        // compare with the value one sample earlier
        next_st.rise = level_in & ~st.prev;
        next_st.fall = ~level_in & st.prev;
    end

    // a signal already high at reset release is seen as a rising edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rise_out = st.rise;
    assign fall_out = st.fall;

endmodule

/* verilog/tei_ctrl.sv */
// Purpose: interrupt enable, live status and sticky flag logic for six edge sources
// Assumes: register slave already runs on the sample clock
// Notes: AXI4-Lite slave accepts one write and one read at a time
`timescale 1ns/1ns
module tei_ctrl #(
    parameter int ADDR_W = tei_pkg::ADDR_W
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // selected timing signals
    input wire logic gate_in,
    input wire logic sync_in,
    input wire logic pulse_second_in,
    // write address channel
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    // write data channel
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [tei_pkg::DATA_W-1:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    // write response channel
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    // read address channel
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    // read data channel
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [tei_pkg::DATA_W-1:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    // interrupt request
    output logic irq_out
);

    typedef struct packed {
        logic [6:0] enable;
        logic [6:0] status;
        logic [6:0] flag;
        logic irq;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [tei_pkg::DATA_W-1:0] rdata;
    } tei_ctrl_state_t;

    tei_ctrl_state_t st;
    tei_ctrl_state_t next_st;

    logic [tei_pkg::NUM_SIGNALS-1:0] signal_level;
    logic [tei_pkg::NUM_SIGNALS-1:0] rising_cond;
    logic [tei_pkg::NUM_SIGNALS-1:0] falling_cond;
    logic [6:0] live_cond;
    logic [6:0] status_rise;
    logic write_fire;
    logic read_fire;
    logic low_lane;
    tei_pkg::tei_reg_sel_t write_sel;
    tei_pkg::tei_reg_sel_t read_sel;

    // word decode, low two address bits ignored
    function automatic tei_pkg::tei_reg_sel_t decode_offset(input logic [5:0] addr);
        tei_pkg::tei_reg_sel_t sel;
        sel = tei_pkg::SEL_NONE;
        if (addr[5:2] == tei_pkg::ENABLE_OFFSET[5:2]) begin
            sel = tei_pkg::SEL_ENABLE;
        end else if (addr[5:2] == tei_pkg::LIVE_STATUS_OFFSET[5:2]) begin
            sel = tei_pkg::SEL_STATUS;
        end else if (addr[5:2] == tei_pkg::FLAG_OFFSET[5:2]) begin
            sel = tei_pkg::SEL_FLAG;
        end
        return sel;
    endfunction

    // order gate, sync, pulse-second matches bit order 0,1,2 and 4,5,6
    assign signal_level = {pulse_second_in, sync_in, gate_in};

    genvar gi;
    generate
        for (gi = 0; gi < tei_pkg::NUM_SIGNALS; gi++) begin : g_src
            tei_edge_source u_edge (
                .clk_in(clk_in),
                .rst_n_in(rst_n_in),
                .level_in(signal_level[gi]),
                .rise_out(rising_cond[gi]),
                .fall_out(falling_cond[gi])
            );
        end
    endgenerate

    // bit 3 stays zero: reserved
    assign live_cond = {falling_cond, 1'b0, rising_cond};

    // write taken only with address and data together and no pending response
    assign write_fire = s_axi_awvalid_in & s_axi_wvalid_in & ~st.bvalid;
    assign read_fire = s_axi_arvalid_in & ~st.rvalid;
    assign low_lane = s_axi_wstrb_in[0];
    assign write_sel = decode_offset(s_axi_awaddr_in[5:0]);
    assign read_sel = decode_offset(s_axi_araddr_in[5:0]);

    // status bits that were zero last cycle and are one now; taken from live_cond
    // rather than next_st so the combinational process does not feed itself
    assign status_rise = live_cond & tei_pkg::FIELD_MASK & ~st.status;

    always_comb begin
        logic [6:0] clear_mask;
        clear_mask = '0;
        next_st = st;

        // status follows the live condition every cycle
        next_st.status = live_cond & tei_pkg::FIELD_MASK;

        // write channel
        if (st.bvalid && s_axi_bready_in) begin
            next_st.bvalid = 1'b0;
        end
        if (write_fire) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = tei_pkg::RESP_OKAY;
            unique case (write_sel)
                tei_pkg::SEL_ENABLE: begin
                    // only implemented bits store
                    if (low_lane) begin
                        next_st.enable = s_axi_wdata_in[6:0] & tei_pkg::FIELD_MASK;
                    end
                end
                tei_pkg::SEL_STATUS: begin
                    // read-only, write accepted and dropped
                end
                tei_pkg::SEL_FLAG: begin
                    // write-one-to-clear
                    if (low_lane) begin
                        clear_mask = s_axi_wdata_in[6:0] & tei_pkg::FIELD_MASK;
                    end
                end
                tei_pkg::SEL_NONE: begin
                    next_st.bresp = tei_pkg::RESP_SLVERR;
                end
            endcase
        end

        // a new occurrence wins over a clear in the same cycle,
        // independent of the enables
        next_st.flag = (st.flag & ~clear_mask) | status_rise;

        // one-cycle pulse, enabled sources ORed
        next_st.irq = |(status_rise & st.enable);

        // read channel
        if (st.rvalid && s_axi_rready_in) begin
            next_st.rvalid = 1'b0;
        end
        if (read_fire) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = tei_pkg::RESP_OKAY;
            next_st.rdata = '0;
            // reserved bits read zero
            unique case (read_sel)
                tei_pkg::SEL_ENABLE: begin
                    next_st.rdata[6:0] = st.enable;
                end
                tei_pkg::SEL_STATUS: begin
                    next_st.rdata[6:0] = st.status;
                end
                tei_pkg::SEL_FLAG: begin
                    next_st.rdata[6:0] = st.flag;
                end
                tei_pkg::SEL_NONE: begin
                    next_st.rresp = tei_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
            st.enable <= tei_pkg::ENABLE_RESET;
            st.status <= tei_pkg::LIVE_STATUS_RESET;
            st.flag <= tei_pkg::FLAG_RESET;
            st.bresp <= tei_pkg::RESP_OKAY;
            st.rresp <= tei_pkg::RESP_OKAY;
        end else begin
            st <= next_st;
        end
    end

    // handshake readies are combinational; data and responses come from flops
    assign s_axi_awready_out = write_fire;
    assign s_axi_wready_out = write_fire;
    assign s_axi_arready_out = ~st.rvalid;
    assign s_axi_bvalid_out = st.bvalid;
    assign s_axi_bresp_out = st.bresp;
    assign s_axi_rvalid_out = st.rvalid;
    assign s_axi_rdata_out = st.rdata;
    assign s_axi_rresp_out = st.rresp;
    assign irq_out = st.irq;

endmodule

/* tb/tei_ctrl_assertions.sv */
// Purpose: port-level checks of the edge interrupt controller
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every tei_ctrl instance
`timescale 1ns/1ns
module tei_ctrl_checker #(
    parameter int ADDR_W = 6
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic gate_in,
    input wire logic sync_in,
    input wire logic pulse_second_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [tei_pkg::DATA_W-1:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // edge seen at one edge gives the pulse two edges later
    a_irq_from_edge: assert property (irq_out |->
        $past({gate_in, sync_in, pulse_second_in}, 2) !=
        $past({gate_in, sync_in, pulse_second_in}, 3))
        else $error("irq pulse without a source edge");
    a_aw_ready: assert property (s_axi_awready_out == (s_axi_awvalid_in && s_axi_wvalid_in
        && !s_axi_bvalid_out)) else $error("awready wrong");
    a_w_ready: assert property (s_axi_wready_out == s_axi_awready_out)
        else $error("wready differs from awready");
    a_b_answer: assert property (s_axi_awvalid_in && s_axi_awready_out |=> s_axi_bvalid_out)
        else $error("no write response");
    a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
    a_ar_ready: assert property (s_axi_arready_out == !s_axi_rvalid_out)
        else $error("arready wrong");
    a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("no read response");
    a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
    a_rsv_zero: assert property (s_axi_rvalid_out |->
        s_axi_rdata_out[31:7] == 25'h0 && !s_axi_rdata_out[3]) else $error("reserved bits set");
    a_unmapped_err: assert property (s_axi_arvalid_in && s_axi_arready_out &&
        !(s_axi_araddr_in[5:2] inside {4'h8, 4'h9, 4'ha}) |=> s_axi_rresp_out == 2'h2)
        else $error("unmapped read not refused");
endmodule
bind tei_ctrl tei_ctrl_checker #(.ADDR_W(ADDR_W)) chk_i (.clk_in, .rst_n_in, .gate_in,
    .sync_in, .pulse_second_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in,
    .s_axi_rdata_out, .s_axi_rresp_out, .irq_out);

/* tb/tei_host.sv */
// Purpose: register host for the controller's AXI4-Lite slave
// Assumes: requests change at the falling edge and hold until answered
// Notes: idle address and data lines carry the inverse of the last value
`timescale 1ns/1ns
module tei_host (
    input wire logic clk_in,
    output logic aw_out,
    output logic [5:0] awaddr_out,
    output logic [31:0] wdata_out,
    output logic [3:0] wstrb_out,
    input wire logic b_in,
    output logic bready_out,
    input wire logic [1:0] bresp_in,
    output logic ar_out,
    output logic [5:0] araddr_out,
    input wire logic r_in,
    output logic rready_out,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in
);
    initial {aw_out, bready_out, ar_out, rready_out, awaddr_out, wdata_out, wstrb_out,
        araddr_out} = '0;
    // answer comes one cycle after the take, so polling falling edges avoids races
    task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] resp);
        @(negedge clk_in);
        {aw_out, awaddr_out, wdata_out, wstrb_out} = {1'b1, a, d, 4'hf};
        do @(negedge clk_in); while (!b_in);
        {aw_out, bready_out, resp} = {2'h1, bresp_in};
        {awaddr_out, wdata_out, wstrb_out} = ~{a, d, 4'hf};
        @(negedge clk_in);
        bready_out = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(negedge clk_in);
        {ar_out, araddr_out} = {1'b1, a};
        do @(negedge clk_in); while (!r_in);
        {ar_out, rready_out, araddr_out, d, resp} = {2'h1, ~a, rdata_in, rresp_in};
        @(negedge clk_in);
        rready_out = 1'b0;
    endtask
endmodule

/* tb/tei_ctrl_tb_top.sv */
// Purpose: self-checking bench of the edge interrupt controller
// Assumes: timing signals and host requests change at the falling edge
// Notes: enables are random per source, the second pass inverts them
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("Error %0t: got %h exp %h", $time, a, b); end end
module tei_ctrl_tb_top;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [2:0] sig = 3'h0;
    logic aw, awr, wr_rdy, bv, br, ar, arr, rv, rr, irq_out;
    logic [5:0] awa, ara;
    logic [31:0] wd, rdat, d, seed = 32'hbafe;
    logic [3:0] ws;
    logic [1:0] bresp, rresp, r;
    logic [6:0] en, fl;
    int err_count = 0, checked = 0, irq_n = 0, n0;
    always #4 clk_in = ~clk_in;
    always @(negedge clk_in) if (irq_out === 1'b1) irq_n++;
    tei_ctrl tei_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .gate_in(sig[0]),
        .sync_in(sig[1]), .pulse_second_in(sig[2]), .s_axi_awvalid_in(aw),
        .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(aw),
        .s_axi_wready_out(wr_rdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_bresp_out(bresp),
        .s_axi_arvalid_in(ar), .s_axi_arready_out(arr), .s_axi_araddr_in(ara),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rresp), .irq_out(irq_out));
    tei_host tei_host_i (.clk_in(clk_in), .aw_out(aw), .awaddr_out(awa), .wdata_out(wd),
        .wstrb_out(ws), .b_in(bv), .bready_out(br), .bresp_in(bresp), .ar_out(ar),
        .araddr_out(ara), .r_in(rv), .rready_out(rr), .rdata_in(rdat), .rresp_in(rresp));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        tei_host_i.rd(a, d, r);
        `CHK({r, d}, {2'h0, e})
    endtask
    task automatic wchk(input logic [5:0] a, input logic [31:0] v);
        tei_host_i.wr(a, v, r);
        `CHK(r, 2'h0)
    endtask
    // moves the masked signals, then counts irq pulses over a settled window
    task automatic ev(input logic [2:0] m, input logic v, input int e);
        n0 = irq_n;
        @(negedge clk_in);
        sig = v ? sig | m : sig & ~m;
        repeat (6) @(negedge clk_in);
        `CHK(irq_n - n0, e)
    endtask
    task automatic tally_and_finish();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(negedge clk_in);
        rst_n_in = 1'b1;
        rchk(6'h20, 0);
        rchk(6'h24, 0);
        rchk(6'h28, 0);
        wchk(6'h20, 32'hffff_ffff);
        rchk(6'h20, 32'h77);
        wchk(6'h24, 32'hffff_ffff);
        rchk(6'h24, 0);
        tei_host_i.rd(6'h04, d, r);
        `CHK(r, 2'h2)
        tei_host_i.wr(6'h04, 32'h0, r);
        `CHK(r, 2'h2)
        rchk(6'h20, 32'h77);
        for (int s = 0; s < 3; s++) begin
            for (int p = 0; p < 2; p++) begin
                // pass 1 inverts the enables of pass 0, so each bit is seen both ways
                if (p == 0) begin
                    seed = lfsr(seed);
                end
                en = (p ? ~seed[6:0] : seed[6:0]) & 7'h77;
                wchk(6'h20, en);
                wchk(6'h28, 32'h77);
                ev(3'h1 << s, 1'b1, en[s]);
                fl = 7'h1 << s;
                rchk(6'h28, fl);
                ev(3'h1 << s, 1'b0, en[s+4]);
                rchk(6'h28, fl | (7'h10 << s));
                rchk(6'h24, 0);
                wchk(6'h28, 32'h1 << s);
                rchk(6'h28, 7'h10 << s);
            end
        end
        wchk(6'h20, 32'h77);
        wchk(6'h28, 32'h77);
        ev(3'h7, 1'b1, 1);
        rchk(6'h28, 32'h7);
        // mid-run reset; signals dropped while in reset so no edge follows release
        @(negedge clk_in);
        rst_n_in = 1'b0;
        sig = 3'h0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        rchk(6'h20, 0);
        rchk(6'h28, 0);
        ev(3'h2, 1'b1, 0);
        rchk(6'h28, 32'h2);
        tally_and_finish();
    end
endmodule
